// File: rtl/fpcs_pkg.sv
package fpcs_pkg;

  // Coprocessor control register indices of the main register and its three views
  localparam logic [4:0] IDX_CC_VIEW = 5'h19;
  localparam logic [4:0] IDX_EXC_VIEW = 5'h1a;
  localparam logic [4:0] IDX_ENA_VIEW = 5'h1c;
  localparam logic [4:0] IDX_MAIN = 5'h1f;

  // Main register field positions
  localparam int CC_HI_HI = 31;
  localparam int CC_HI_LO = 25;
  localparam int FS_POS = 24;
  localparam int CC_LO_POS = 23;
  localparam int FO_POS = 22;
  localparam int FN_POS = 21;
  localparam int CAUSE_HI = 17;
  localparam int CAUSE_LO = 12;
  localparam int EN_HI = 11;
  localparam int EN_LO = 7;
  localparam int FLAG_HI = 6;
  localparam int FLAG_LO = 2;
  localparam int RM_HI = 1;
  localparam int RM_LO = 0;

  // Condition-code view and enables view positions
  localparam int CCV_HI = 7;
  localparam int CCV_LO = 0;
  localparam int ENV_FS_POS = 2;

  // Cause bit order: E V Z O U I, E on top
  localparam int CAUSE_E = 5;
  localparam int NUM_CAUSE = 6;
  localparam int NUM_IEEE = 5;
  localparam int NUM_CC = 8;

  // Condition-code index field inside instruction words
  localparam int CMP_CC_LSB = 8;
  localparam int BR_CC_LSB = 18;
  localparam int CC_IDX_W = 3;

  // Reset values (hardware leaves them undefined; zero is chosen)
  localparam logic [7:0] CC_RST = 8'h00;
  localparam logic [5:0] CAUSE_RST = 6'h00;
  localparam logic [4:0] IEEE_RST = 5'h00;
  localparam logic [1:0] RM_RST = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    RM_NEAREST_EVEN = 2'h0,
    RM_TOWARD_ZERO = 2'h1,
    RM_TOWARD_PLUS = 2'h2,
    RM_TOWARD_MINUS = 2'h3
  } fpcs_rm_t;

endpackage : fpcs_pkg

// File: rtl/fpcs_cc_sel.sv
`timescale 1ns/10ps
module fpcs_cc_sel #(
  parameter int LSB = fpcs_pkg::CMP_CC_LSB
) (
  // Instruction word
  input wire logic [31:0] insn,
  // Stored condition codes
  input wire logic [fpcs_pkg::NUM_CC-1:0] cc,
  // Decoded index and selected bit
  output logic [fpcs_pkg::CC_IDX_W-1:0] idx,
  output logic bit_value
);

  assign idx = insn[LSB +: fpcs_pkg::CC_IDX_W];
  assign bit_value = cc[idx];

endmodule : fpcs_cc_sel

// File: rtl/fpcs_regs.sv
`timescale 1ns/10ps
module fpcs_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Coprocessor move port
  input wire logic cp_usable,
  input wire logic cp_wr_en,
  input wire logic cp_rd_en,
  input wire logic [4:0] cp_index,
  input wire logic [31:0] cp_wdata,
  output logic [31:0] cp_rdata,
  output logic cp_rd_valid,
  // Arithmetic completion
  input wire logic op_done,
  input wire logic [fpcs_pkg::NUM_CAUSE-1:0] op_cause,
  // Compare completion
  input wire logic cmp_done,
  input wire logic [31:0] cmp_insn,
  input wire logic cmp_result,
  // Branch or conditional move test
  input wire logic [31:0] br_insn,
  output logic br_cc_value,
  // Controls to the datapath
  output logic [1:0] rounding_select,
  output logic [3:0] round_onehot,
  output logic flush_to_zero_ctl,
  output logic flush_override_ctl,
  output logic flush_nearest_ctl,
  // Exception trap request
  output logic trap_req
);

  typedef struct packed {
    logic [fpcs_pkg::NUM_CC-1:0] cc;
    logic fs;
    logic fo;
    logic fn;
    // Six causes, five IEEE enables and flags
    // Unimplemented on top, then V Z O U I
    logic [fpcs_pkg::NUM_CAUSE-1:0] cause;
    logic [fpcs_pkg::NUM_IEEE-1:0] en;
    logic [fpcs_pkg::NUM_IEEE-1:0] flags;
    logic [1:0] rm;
    logic [31:0] rdata;
    logic rd_valid;
    logic trap;
  } fpcs_state_t;

  fpcs_state_t s;
  fpcs_state_t next_s;
  logic [fpcs_pkg::CC_IDX_W-1:0] cmp_idx;
  logic [fpcs_pkg::CC_IDX_W-1:0] br_idx;
  logic wr_ok;
  logic rd_ok;

  function automatic logic trap_of(
    input logic [fpcs_pkg::NUM_CAUSE-1:0] c,
    input logic [fpcs_pkg::NUM_IEEE-1:0] e
  );
    trap_of = c[fpcs_pkg::CAUSE_E] | (|(c[fpcs_pkg::NUM_IEEE-1:0] & e));
  endfunction : trap_of

  function automatic logic [31:0] main_word(input fpcs_state_t x);
    logic [31:0] w;
    w = fpcs_pkg::WORD_ZERO;
    w[fpcs_pkg::CC_HI_HI:fpcs_pkg::CC_HI_LO] = x.cc[7:1];
    w[fpcs_pkg::FS_POS] = x.fs;
    w[fpcs_pkg::CC_LO_POS] = x.cc[0];
    w[fpcs_pkg::FO_POS] = x.fo;
    w[fpcs_pkg::FN_POS] = x.fn;
    w[fpcs_pkg::CAUSE_HI:fpcs_pkg::CAUSE_LO] = x.cause;
    w[fpcs_pkg::EN_HI:fpcs_pkg::EN_LO] = x.en;
    w[fpcs_pkg::FLAG_HI:fpcs_pkg::FLAG_LO] = x.flags;
    w[fpcs_pkg::RM_HI:fpcs_pkg::RM_LO] = x.rm;
    main_word = w;
  endfunction : main_word

  fpcs_cc_sel #(
    .LSB(fpcs_pkg::CMP_CC_LSB)
  ) u_cmp_sel (
    .insn(cmp_insn),
    .cc(s.cc),
    .idx(cmp_idx),
    .bit_value()
  );

  fpcs_cc_sel #(
    .LSB(fpcs_pkg::BR_CC_LSB)
  ) u_br_sel (
    .insn(br_insn),
    .cc(s.cc),
    .idx(br_idx),
    .bit_value(br_cc_value)
  );

  // Only the usable enable gates access
  assign wr_ok = cp_wr_en & cp_usable;
  assign rd_ok = cp_rd_en & cp_usable;

  always_comb begin
    logic [31:0] w;
    logic op_traps;
    w = cp_wdata;
    op_traps = 1'b0;
    next_s = s;
    next_s.rd_valid = 1'b0;
    // Software writes first; hardware events below override the indexed cc bit and cause, and OR untrapped causes into the written flags
    if (wr_ok) begin
      unique case (cp_index)
        fpcs_pkg::IDX_MAIN: begin
          next_s.cc = {w[fpcs_pkg::CC_HI_HI:fpcs_pkg::CC_HI_LO],
                       w[fpcs_pkg::CC_LO_POS]};
          next_s.fs = w[fpcs_pkg::FS_POS];
          next_s.fo = w[fpcs_pkg::FO_POS];
          next_s.fn = w[fpcs_pkg::FN_POS];
          next_s.cause = w[fpcs_pkg::CAUSE_HI:fpcs_pkg::CAUSE_LO];
          next_s.en = w[fpcs_pkg::EN_HI:fpcs_pkg::EN_LO];
          next_s.flags = w[fpcs_pkg::FLAG_HI:fpcs_pkg::FLAG_LO];
          next_s.rm = w[fpcs_pkg::RM_HI:fpcs_pkg::RM_LO];
        end
        fpcs_pkg::IDX_CC_VIEW: begin
          next_s.cc = w[fpcs_pkg::CCV_HI:fpcs_pkg::CCV_LO];
        end
        fpcs_pkg::IDX_EXC_VIEW: begin
          next_s.cause = w[fpcs_pkg::CAUSE_HI:fpcs_pkg::CAUSE_LO];
          next_s.flags = w[fpcs_pkg::FLAG_HI:fpcs_pkg::FLAG_LO];
        end
        fpcs_pkg::IDX_ENA_VIEW: begin
          next_s.en = w[fpcs_pkg::EN_HI:fpcs_pkg::EN_LO];
          next_s.fs = w[fpcs_pkg::ENV_FS_POS];
          next_s.rm = w[fpcs_pkg::RM_HI:fpcs_pkg::RM_LO];
        end
        // Unmapped index: write dropped
        default: begin
        end
      endcase
    end
    if (cmp_done) begin
      next_s.cc[cmp_idx] = cmp_result;
    end
    if (op_done) begin
      next_s.cause = op_cause;
      op_traps = trap_of(op_cause, next_s.en);
      if (!op_traps) begin
        next_s.flags = next_s.flags | op_cause[fpcs_pkg::NUM_IEEE-1:0];
      end
    end
    next_s.trap = trap_of(next_s.cause, next_s.en);
    if (rd_ok) begin
      next_s.rd_valid = 1'b1;
      unique case (cp_index)
        fpcs_pkg::IDX_MAIN: next_s.rdata = main_word(s);
        fpcs_pkg::IDX_CC_VIEW: begin
          next_s.rdata = fpcs_pkg::WORD_ZERO;
          next_s.rdata[fpcs_pkg::CCV_HI:fpcs_pkg::CCV_LO] = s.cc;
        end
        fpcs_pkg::IDX_EXC_VIEW: begin
          next_s.rdata = fpcs_pkg::WORD_ZERO;
          next_s.rdata[fpcs_pkg::CAUSE_HI:fpcs_pkg::CAUSE_LO] = s.cause;
          next_s.rdata[fpcs_pkg::FLAG_HI:fpcs_pkg::FLAG_LO] = s.flags;
        end
        fpcs_pkg::IDX_ENA_VIEW: begin
          next_s.rdata = fpcs_pkg::WORD_ZERO;
          next_s.rdata[fpcs_pkg::EN_HI:fpcs_pkg::EN_LO] = s.en;
          next_s.rdata[fpcs_pkg::ENV_FS_POS] = s.fs;
          next_s.rdata[fpcs_pkg::RM_HI:fpcs_pkg::RM_LO] = s.rm;
        end
        default: next_s.rdata = fpcs_pkg::WORD_ZERO;
      endcase
    end
  end

  // Reset to zero, though software must not rely on it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s.cc <= fpcs_pkg::CC_RST;
      s.fs <= 1'b0;
      s.fo <= 1'b0;
      s.fn <= 1'b0;
      s.cause <= fpcs_pkg::CAUSE_RST;
      s.en <= fpcs_pkg::IEEE_RST;
      s.flags <= fpcs_pkg::IEEE_RST;
      s.rm <= fpcs_pkg::RM_RST;
      s.rdata <= fpcs_pkg::WORD_ZERO;
      s.rd_valid <= 1'b0;
      s.trap <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign cp_rdata = s.rdata;
  assign cp_rd_valid = s.rd_valid;
  assign rounding_select = s.rm;
  assign flush_to_zero_ctl = s.fs;
  assign flush_override_ctl = s.fo;
  assign flush_nearest_ctl = s.fn;
  assign trap_req = s.trap;

  assign round_onehot = {s.rm == fpcs_pkg::RM_TOWARD_MINUS,
                         s.rm == fpcs_pkg::RM_TOWARD_PLUS,
                         s.rm == fpcs_pkg::RM_TOWARD_ZERO,
                         s.rm == fpcs_pkg::RM_NEAREST_EVEN};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_CAUSE_LOAD: assert property (
    op_done |=> s.cause == $past(op_cause))
    else $error("cause field not loaded from operation");

  AST_TRAP_PAIR: assert property (
    (|(s.cause[4:0] & s.en)) |-> trap_req)
    else $error("enabled cause without trap");

  AST_TRAP_ONLY_CAUSE: assert property (
    trap_req |-> trap_of(s.cause, s.en))
    else $error("trap without matching cause");

  AST_TRAP_ON_WRITE: assert property (
    (wr_ok && cp_index == fpcs_pkg::IDX_EXC_VIEW && !op_done &&
     (|(cp_wdata[16:12] & s.en))) |=> trap_req)
    else $error("software write did not raise trap");

  AST_UNIMPL_TRAP: assert property (
    s.cause[fpcs_pkg::CAUSE_E] |-> trap_req)
    else $error("unimplemented cause did not trap");

  AST_FLAGS_SET: assert property (
    (op_done && !wr_ok && !trap_of(op_cause, s.en)) |=>
      s.flags == ($past(s.flags) | $past(op_cause[4:0])))
    else $error("untrapped op did not set flags");

  AST_FLAGS_HOLD_TRAP: assert property (
    (op_done && !wr_ok && trap_of(op_cause, s.en)) |=> $stable(s.flags))
    else $error("trapping op changed flags");

  AST_FLAGS_NO_CLEAR: assert property (
    !wr_ok |=> (s.flags & $past(s.flags)) == $past(s.flags))
    else $error("flag cleared without write");

  AST_RESERVED_ZERO: assert property (
    (rd_ok && cp_index == fpcs_pkg::IDX_MAIN) |=>
      cp_rd_valid && cp_rdata[20:18] == 3'h0)
    else $error("reserved bits not zero");

  AST_CC_COMPARE: assert property (
    cmp_done |=> s.cc[$past(cmp_idx)] == $past(cmp_result))
    else $error("compare result not stored");

  AST_CC_VIEW_READ: assert property (
    (rd_ok && cp_index == fpcs_pkg::IDX_CC_VIEW) |=>
      cp_rdata == {24'h000000, $past(s.cc)})
    else $error("condition view read mismatch");

  AST_ENA_VIEW_WRITE: assert property (
    (wr_ok && cp_index == fpcs_pkg::IDX_ENA_VIEW && !op_done) |=>
      s.en == $past(cp_wdata[11:7]) && s.fs == $past(cp_wdata[2]) &&
      s.rm == $past(cp_wdata[1:0]))
    else $error("enables view write mismatch");

  AST_NO_ACCESS: assert property (
    (cp_rd_en && !cp_usable) |=> !cp_rd_valid)
    else $error("read answered while unusable");

  AST_ROUND_ONEHOT: assert property (
    $onehot(round_onehot))
    else $error("rounding decode not one-hot");

  COV_OP_TRAP: cover property (op_done ##1 trap_req);
  COV_FLAG_SET: cover property (op_done ##1 $changed(s.flags));
  COV_WRITE_TRAP: cover property (wr_ok ##1 $rose(trap_req));
  COV_CMP_BRANCH: cover property (cmp_done ##1 br_cc_value);

endmodule : fpcs_regs

// File: verification/fpcs_pipe_model.sv
`timescale 1ns/10ps
module fpcs_pipe_model (
  // Clock
  input wire logic sys_clk,
  // Branch index chosen by the bench
  input wire logic [2:0] br_sel,
  // Arithmetic completion
  output logic op_done,
  output logic [5:0] op_cause,
  // Compare and branch words
  output logic cmp_done,
  output logic [31:0] cmp_insn,
  output logic cmp_result,
  output logic [31:0] br_insn
);
  initial begin
    op_done = 1'b0;
    op_cause = 6'h00;
    cmp_done = 1'b0;
    cmp_insn = 32'h0000_0000;
    cmp_result = 1'b0;
  end

  // index inside branch word, follows the bench's pick
  assign br_insn = 32'(br_sel) << fpcs_pkg::BR_CC_LSB;

  task automatic arith(input logic [5:0] c);
    @(posedge sys_clk);
    #1;
    op_done = 1'b1;
    op_cause = c;
    @(posedge sys_clk);
    #1;
    op_done = 1'b0;
    // Stale cause inverted so nothing leans on a held value
    op_cause = ~c;
  endtask : arith

  task automatic compare(input logic [2:0] idx, input logic res);
    @(posedge sys_clk);
    #1;
    cmp_done = 1'b1;
    cmp_insn = 32'(idx) << fpcs_pkg::CMP_CC_LSB;
    cmp_result = res;
    @(posedge sys_clk);
    #1;
    cmp_done = 1'b0;
    cmp_insn = ~cmp_insn;
    cmp_result = ~res;
  endtask : compare
endmodule : fpcs_pipe_model

// File: verification/fpcs_regs_test.sv
`timescale 1ns/10ps
module fpcs_regs_test;
  logic sys_clk, sys_rst, cp_usable, cp_wr_en, cp_rd_en, cp_rd_valid;
  logic [4:0] cp_index;
  logic [31:0] cp_wdata, cp_rdata, cmp_insn, br_insn;
  logic op_done, cmp_done, cmp_result, br_cc_value, trap_req;
  logic [5:0] op_cause;
  logic [2:0] br_sel;
  logic [1:0] rounding_select;
  logic [3:0] round_onehot;
  logic flush_to_zero_ctl, flush_override_ctl, flush_nearest_ctl;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  fpcs_regs dut (
    .sys_clk, .sys_rst, .cp_usable, .cp_wr_en, .cp_rd_en, .cp_index,
    .cp_wdata, .cp_rdata, .cp_rd_valid, .op_done, .op_cause, .cmp_done,
    .cmp_insn, .cmp_result, .br_insn, .br_cc_value, .rounding_select,
    .round_onehot, .flush_to_zero_ctl, .flush_override_ctl,
    .flush_nearest_ctl, .trap_req
  );

  fpcs_pipe_model pm (
    .sys_clk, .br_sel, .op_done, .op_cause, .cmp_done, .cmp_insn,
    .cmp_result, .br_insn
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Whole run needs about 120 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    cp_wr_en = 1'b1;
    cp_index = idx;
    cp_wdata = d;
    @(posedge sys_clk);
    #1;
    cp_wr_en = 1'b0;
  endtask : wr

  // Data only checked when the move is allowed to act
  task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
    @(posedge sys_clk);
    #1;
    cp_rd_en = 1'b1;
    cp_index = idx;
    @(posedge sys_clk);
    #1;
    cp_rd_en = 1'b0;
    chk("rd_valid", 32'(cp_rd_valid), 32'(cp_usable));
    if (cp_usable) chk("rd_data", cp_rdata, exp);
  endtask : rd

  initial begin
    sys_rst = 1'b1;
    cp_usable = 1'b1;
    cp_wr_en = 1'b0;
    cp_rd_en = 1'b0;
    cp_index = 5'h00;
    cp_wdata = 32'h0000_0000;
    br_sel = 3'h0;
    repeat (16) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;

    wr(5'h1f, 32'hffff_ffff);
    rd(5'h1f, 32'hffe3_ffff);
    chk("flush", {29'h0, flush_to_zero_ctl, flush_override_ctl,
                  flush_nearest_ctl}, 32'h7);
    chk("trap", 32'(trap_req), 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(5'h1f, 32'(m));
      chk("rm", {26'h0, round_onehot, rounding_select},
          32'((1 << (m + 2)) | m));
    end
    chk("trap", 32'(trap_req), 32'h0);
    $display("test main_map finished");

    wr(5'h19, 32'h0000_00a5);
    rd(5'h1f, 32'ha480_0003);
    rd(5'h19, 32'h0000_00a5);
    wr(5'h1c, 32'h0000_0f87);
    rd(5'h1f, 32'ha580_0f83);
    rd(5'h1c, 32'h0000_0f87);
    wr(5'h1c, 32'h0000_0001);
    wr(5'h1a, 32'h0003_f07c);
    chk("trap", 32'(trap_req), 32'h1);
    rd(5'h1a, 32'h0003_f07c);
    wr(5'h1a, 32'h0000_0000);
    chk("trap", 32'(trap_req), 32'h0);
    $display("test views finished");

    pm.arith(6'h0a);
    rd(5'h1a, 32'h0000_a028);
    pm.arith(6'h11);
    rd(5'h1a, 32'h0001_106c);
    pm.arith(6'h00);
    rd(5'h1a, 32'h0000_006c);
    $display("test sticky_flags finished");

    wr(5'h1c, 32'h0000_0401);
    wr(5'h1a, 32'h0000_806c);
    chk("trap", 32'(trap_req), 32'h1);
    pm.arith(6'h08);
    chk("trap", 32'(trap_req), 32'h1);
    rd(5'h1a, 32'h0000_806c);
    pm.arith(6'h20);
    chk("trap", 32'(trap_req), 32'h1);
    rd(5'h1a, 32'h0002_006c);
    pm.arith(6'h04);
    chk("trap", 32'(trap_req), 32'h0);
    rd(5'h1a, 32'h0000_407c);
    wr(5'h1a, 32'h0000_0000);
    rd(5'h1a, 32'h0000_0000);
    $display("test traps finished");

    for (int i = 0; i < 8; i++) pm.compare(3'(i), i[0]);
    rd(5'h19, 32'h0000_00aa);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      #1;
      br_sel = 3'(i);
      #1;
      chk("br_cc", 32'(br_cc_value), 32'(i[0]));
    end
    $display("test condition_codes finished");

    @(posedge sys_clk);
    #1;
    cp_usable = 1'b0;
    wr(5'h1f, 32'h0000_0000);
    rd(5'h1f, 32'h0000_0000);
    chk("rm", 32'(rounding_select), 32'h1);
    cp_usable = 1'b1;
    wr(5'h1e, 32'h0000_0000);
    rd(5'h00, 32'h0000_0000);
    rd(5'h1c, 32'h0000_0401);
    $display("test access finished");
    print_verdict();
  end
endmodule : fpcs_regs_test
